// ==== distributed_dma_pkg.sv ====
// distributed dma register block: offsets, reset values and state layouts
// assumes one clock domain; all users import the whole package
package distributed_dma_pkg;

  // ==========================================================
  // configuration space
  localparam logic [7:0]  CFG_DMA_BASE_OFS   = 8'h98;
  localparam logic [15:0] IO_BASE_WR_MASK    = 16'hFFF0;
  localparam logic [15:0] IO_BASE_RESET      = 16'h0000;

  // ==========================================================
  // byte offsets inside the 16-byte i/o window
  localparam logic [3:0] OFS_ADDR_LO     = 4'h0;
  localparam logic [3:0] OFS_ADDR_HI     = 4'h1;
  localparam logic [3:0] OFS_PAGE        = 4'h2;
  localparam logic [3:0] OFS_COUNT_LO    = 4'h4;
  localparam logic [3:0] OFS_COUNT_HI    = 4'h5;
  localparam logic [3:0] OFS_STAT_CMD    = 4'h8;
  localparam logic [3:0] OFS_REQUEST     = 4'h9;
  localparam logic [3:0] OFS_MODE        = 4'hB;
  localparam logic [3:0] OFS_MASTER_CLR  = 4'hD;
  localparam logic [3:0] OFS_MULTI_MASK  = 4'hF;

  // ==========================================================
  // field positions and reset values
  localparam int          CMD_ENABLE_N_BIT = 2;
  localparam int          MODE_LSB         = 2;
  localparam logic [15:0] ADDR_RESET       = 16'h0000;
  localparam logic [15:0] COUNT_RESET      = 16'h0000;
  localparam logic [7:0]  PAGE_RESET       = 8'h00;
  localparam logic [5:0]  MODE_RESET       = 6'h00;
  localparam logic [3:0]  MASK_RESET       = 4'hF;
  localparam logic [15:0] STEP_8BIT        = 16'h0001;
  localparam logic [15:0] STEP_16BIT       = 16'h0002;

  // ==========================================================
  // state of the register block
  typedef struct packed {
    logic [15:0] io_base;
    logic [15:0] base_addr;
    logic [15:0] cur_addr;
    logic [15:0] base_count;
    logic [15:0] cur_count;
    logic [7:0]  page;
    logic        enable_n;
    logic [3:0]  tc;
    logic [5:0]  mode;
    logic [3:0]  mask;
    logic        soft_req;
    logic [7:0]  io_rdata;
    logic [31:0] cfg_rdata;
    logic        dreq_s1;
    logic        dreq_s2;
  } regs_type;

  // state of the address phase driver
  typedef struct packed {
    logic [31:0] ad;
    logic        oe;
  } ad_phase_type;

endpackage

// ==== address_phase_former.sv ====
// forms the transfer address driven on the address/data lines
// assumes start is a one-cycle pulse on the same clock
`timescale 1ns/1ps

module address_phase_former
  import distributed_dma_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        start,
  input  wire logic        wide,
  input  wire logic [15:0] cur_addr,
  input  wire logic [7:0]  page,
  output logic      [31:0] ad,
  output logic             ad_oe
);

  ad_phase_type s_q;
  ad_phase_type s_d;

  // ==========================================================
  // address phase
  always_comb begin
    s_d    = s_q;
    s_d.oe = start;
    if (start) begin
      if (wide) begin
        // word addressing: page bit 0 dropped, line 0 low
        s_d.ad = {8'h00, page[7:1], cur_addr, 1'b0};
      end else begin
        s_d.ad = {8'h00, page, cur_addr};
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign ad    = s_q.ad;
  assign ad_oe = s_q.oe;

endmodule

// ==== distributed_dma_regs.sv ====
// distributed dma slave register block with its address phase output
// assumes config and i/o strobes are one-cycle pulses on CLK;
// the card request line is asynchronous and is synchronised here
`timescale 1ns/1ps

// Operation
// - configuration offset 98h holds the programmable i/o base of the block.
// - a 16-byte i/o window from that base is decoded as the block.
// - legacy bits without meaning here are read-only and do nothing.
// - reserved locations are read-only and read as zero.
// - writes to reserved locations are dropped and change nothing.
// - offset 00h takes start address on write, reads present address.
// - offset 02h is the readable and writable upper address page byte.
// - 04h count, 08h status/command/request/mode, 0Ch multichannel/mask/clear.
// - byte mode drives current address onto lines 15 to 0.
// - byte mode drives all eight page bits onto lines 23 to 16.
// - word mode drives current address onto lines 16 to 1, line 0 low.
// - word mode drives page bits 7 to 1 onto lines 23 to 17.
// - count drops by one per byte transfer, by two per word.
// - command enable bit is active low and enabled after reset.
module distributed_dma_regs
  import distributed_dma_pkg::*;
(
  input  wire logic        CLK,
  input  wire logic        RESET,
  input  wire logic        CFG_WR,
  input  wire logic        CFG_RD,
  input  wire logic [7:0]  CFG_ADDR,
  input  wire logic [31:0] CFG_WDATA,
  output logic      [31:0] CFG_RDATA,
  input  wire logic        IO_WR,
  input  wire logic        IO_RD,
  input  wire logic [15:0] IO_ADDR,
  input  wire logic [7:0]  IO_WDATA,
  output logic      [7:0]  IO_RDATA,
  output logic             IO_HIT,
  input  wire logic        CARD_DREQ,
  input  wire logic        XFER_WIDE,
  input  wire logic        XFER_DONE,
  input  wire logic        ADDR_PHASE,
  output logic      [31:0] AD_OUT,
  output logic             AD_OE,
  output logic             CONTROLLER_ENABLE,
  output logic             SOFT_REQUEST,
  output logic      [5:0]  MODE_BITS,
  output logic             CHANNEL_MASKED,
  output logic             TERMINAL_COUNT
);

  regs_type r_q;
  regs_type r_d;

  // ==========================================================
  // decode helpers
  function automatic logic window_hit(input logic [15:0] addr, input logic [15:0] base);
    // an unprogrammed base claims nothing, so a cleared pointer stays silent
    window_hit = (base != 16'h0000) && (addr[15:4] == base[15:4]);
  endfunction

  function automatic logic io_sel(input logic strobe, input logic [15:0] addr,
                                  input logic [15:0] base, input logic [3:0] ofs);
    io_sel = strobe && window_hit(addr, base) && (addr[3:0] == ofs);
  endfunction

  logic        active;
  logic [15:0] step;
  logic [15:0] next_count;
  logic        borrow;
  logic        tc_clear;
  logic        master_clear;

  assign active       = !r_q.enable_n;
  assign step         = XFER_WIDE ? STEP_16BIT : STEP_8BIT;
  assign next_count   = r_q.cur_count - step;
  assign borrow       = r_q.cur_count < step;
  assign tc_clear     = io_sel(IO_RD, IO_ADDR, r_q.io_base, OFS_STAT_CMD);
  assign master_clear = io_sel(IO_WR, IO_ADDR, r_q.io_base, OFS_MASTER_CLR);

  // ==========================================================
  // next state
  always_comb begin
    r_d = r_q;

    // two-stage synchroniser for the card request pin
    r_d.dreq_s1 = CARD_DREQ;
    r_d.dreq_s2 = r_q.dreq_s1;

    // configuration space pointer
    if (CFG_WR && CFG_ADDR == CFG_DMA_BASE_OFS) begin
      r_d.io_base = CFG_WDATA[15:0] & IO_BASE_WR_MASK;
    end
    if (CFG_RD) begin
      r_d.cfg_rdata = (CFG_ADDR == CFG_DMA_BASE_OFS) ? {16'h0000, r_q.io_base} : 32'h0000_0000;
    end

    // read of the i/o window; holes and write-only bytes read zero
    if (IO_RD && window_hit(IO_ADDR, r_q.io_base)) begin
      case (IO_ADDR[3:0])
        OFS_ADDR_LO:    r_d.io_rdata = r_q.cur_addr[7:0];
        OFS_ADDR_HI:    r_d.io_rdata = r_q.cur_addr[15:8];
        OFS_PAGE:       r_d.io_rdata = r_q.page;
        OFS_COUNT_LO:   r_d.io_rdata = r_q.cur_count[7:0];
        OFS_COUNT_HI:   r_d.io_rdata = r_q.cur_count[15:8];
        OFS_STAT_CMD:   r_d.io_rdata = {{4{r_q.dreq_s2}}, r_q.tc};
        OFS_MULTI_MASK: r_d.io_rdata = {4'h0, r_q.mask};
        default:        r_d.io_rdata = 8'h00;
      endcase
    end

    // writes; any offset not listed falls through untouched
    if (IO_WR && window_hit(IO_ADDR, r_q.io_base)) begin
      case (IO_ADDR[3:0])
        OFS_ADDR_LO: begin
          r_d.base_addr[7:0] = IO_WDATA;
          r_d.cur_addr[7:0]  = IO_WDATA;
        end
        OFS_ADDR_HI: begin
          r_d.base_addr[15:8] = IO_WDATA;
          r_d.cur_addr[15:8]  = IO_WDATA;
        end
        OFS_PAGE: begin
          r_d.page = IO_WDATA;
        end
        OFS_COUNT_LO: begin
          r_d.base_count[7:0] = IO_WDATA;
          r_d.cur_count[7:0]  = IO_WDATA;
        end
        OFS_COUNT_HI: begin
          r_d.base_count[15:8] = IO_WDATA;
          r_d.cur_count[15:8]  = IO_WDATA;
        end
        OFS_STAT_CMD: begin
          // only the enable bit exists, the rest of the byte is dropped
          r_d.enable_n = IO_WDATA[CMD_ENABLE_N_BIT];
        end
        OFS_REQUEST: begin
          r_d.soft_req = 1'b1;
        end
        OFS_MODE: begin
          r_d.mode = IO_WDATA[7:MODE_LSB];
        end
        OFS_MULTI_MASK: begin
          r_d.mask = IO_WDATA[3:0];
        end
        default: begin
        end
      endcase
    end

    // status clears on read; a terminal count in the same cycle still sets it
    if (tc_clear) begin
      r_d.tc = 4'h0;
    end

    // a completed transfer advances address and count
    if (XFER_DONE && active) begin
      r_d.cur_addr  = r_q.cur_addr + 16'h0001;
      r_d.cur_count = next_count;
      if (borrow) begin
        r_d.tc = 4'hF;
      end
    end

    if (master_clear) begin
      r_d.enable_n = 1'b0;
      r_d.tc       = 4'h0;
      r_d.mode     = MODE_RESET;
      r_d.mask     = MASK_RESET;
      r_d.soft_req = 1'b0;
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge CLK) begin
    if (RESET) begin
      r_q            <= '0;
      r_q.io_base    <= IO_BASE_RESET;
      r_q.base_addr  <= ADDR_RESET;
      r_q.cur_addr   <= ADDR_RESET;
      r_q.base_count <= COUNT_RESET;
      r_q.cur_count  <= COUNT_RESET;
      r_q.page       <= PAGE_RESET;
      r_q.enable_n   <= 1'b0;
      r_q.mode       <= MODE_RESET;
      r_q.mask       <= MASK_RESET;
    end else begin
      r_q <= r_d;
    end
  end

  // ==========================================================
  // address phase driver
  address_phase_former u_former (
    .clk      (CLK),
    .reset    (RESET),
    .start    (ADDR_PHASE && active),
    .wide     (XFER_WIDE),
    .cur_addr (r_q.cur_addr),
    .page     (r_q.page),
    .ad       (AD_OUT),
    .ad_oe    (AD_OE)
  );

  // ==========================================================
  // outputs
  assign IO_HIT            = (IO_RD || IO_WR) && window_hit(IO_ADDR, r_q.io_base);
  assign IO_RDATA          = r_q.io_rdata;
  assign CFG_RDATA         = r_q.cfg_rdata;
  assign CONTROLLER_ENABLE = active;
  assign SOFT_REQUEST      = r_q.soft_req;
  assign MODE_BITS         = r_q.mode;
  assign CHANNEL_MASKED    = r_q.mask[0];
  assign TERMINAL_COUNT    = r_q.tc[0];

endmodule

// ==== distributed_dma_assertions.sv ====
// checker for the dma register block ports
// assumes bind onto distributed_dma_regs, one clock domain
`timescale 1ns/1ps

module distributed_dma_assertions (
  input wire logic        CLK,
  input wire logic        RESET,
  input wire logic        CFG_RD,
  input wire logic [31:0] CFG_RDATA,
  input wire logic        IO_WR,
  input wire logic        IO_RD,
  input wire logic        IO_HIT,
  input wire logic        XFER_WIDE,
  input wire logic        ADDR_PHASE,
  input wire logic [31:0] AD_OUT,
  input wire logic        AD_OE,
  input wire logic        CONTROLLER_ENABLE
);
  // ==========================================================
  // properties
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);

  a_phase_gives_oe: assert property (ADDR_PHASE && CONTROLLER_ENABLE |=> AD_OE)
    else $error("address phase gave no output enable");
  a_oe_has_cause: assert property (AD_OE |-> $past(ADDR_PHASE))
    else $error("output enable without address phase");
  a_ad_held: assert property (!$past(ADDR_PHASE) |-> $stable(AD_OUT))
    else $error("address changed without address phase");
  a_upper_zero: assert property (AD_OE |-> AD_OUT[31:24] == 8'h00)
    else $error("address bits above page not zero");
  a_word_lsb_low: assert property (AD_OE && $past(XFER_WIDE) |-> !AD_OUT[0])
    else $error("word mode address bit zero not low");
  a_disabled_quiet: assert property (ADDR_PHASE && !CONTROLLER_ENABLE |=> !AD_OE)
    else $error("address phase driven while disabled");
  a_enabled_reset: assert property ($past(RESET) |-> CONTROLLER_ENABLE)
    else $error("controller not enabled after reset");
  a_hit_needs_strobe: assert property (IO_HIT |-> IO_WR || IO_RD)
    else $error("window hit without strobe");
  a_cfg_base_fmt: assert property ($past(CFG_RD) |-> CFG_RDATA[3:0] == 4'h0)
    else $error("base pointer low bits not zero");
endmodule

bind distributed_dma_regs distributed_dma_assertions distributed_dma_assertions_i (
  .CLK(CLK), .RESET(RESET), .CFG_RD(CFG_RD), .CFG_RDATA(CFG_RDATA), .IO_WR(IO_WR),
  .IO_RD(IO_RD), .IO_HIT(IO_HIT), .XFER_WIDE(XFER_WIDE), .ADDR_PHASE(ADDR_PHASE),
  .AD_OUT(AD_OUT), .AD_OE(AD_OE), .CONTROLLER_ENABLE(CONTROLLER_ENABLE));

// ==== dma_master_model.sv ====
// master dma device: requests address phases and transfers
// assumes the bench calls its tasks; drives at falling edges
`timescale 1ns/1ps

module dma_master_model (
  input  wire logic        clk,
  input  wire logic [31:0] ad,
  input  wire logic        ad_oe,
  output logic             wide,
  output logic             done,
  output logic             phase_req,
  output logic             dreq
);
  logic [31:0] got_ad;
  logic        got_oe;

  initial begin
    wide = 1'b0;
    done = 1'b0;
    phase_req = 1'b0;
    dreq = 1'b0;
  end

  // width is held through the phase so the former sees one mode
  task automatic phase(input logic w);
    @(negedge clk);
    wide = w;
    phase_req = 1'b1;
    @(negedge clk);
    phase_req = 1'b0;
    got_oe = ad_oe;
    got_ad = ad;
  endtask

  // the card moves its request line between clock edges, as a pin would
  task automatic request(input logic level);
    @(negedge clk);
    dreq = level;
  endtask

  task automatic xfer(input logic w);
    @(negedge clk);
    wide = w;
    done = 1'b1;
    @(negedge clk);
    done = 1'b0;
  endtask
endmodule

// ==== tb_distributed_dma_regs.sv ====
// testbench for the dma register block
// assumes the master model drives the transfer side
`timescale 1ns/1ps

module tb_distributed_dma_regs
  import distributed_dma_pkg::*;
;
  localparam logic [15:0] B = 16'h0300;
  logic clk = 0, rst = 1, cfg_wr = 0, cfg_rd = 0, io_wr = 0, io_rd = 0, h, oe;
  logic [7:0] cfg_addr = 8'h00, io_wdata = 8'h00, io_rdata;
  logic [31:0] cfg_wdata = 32'h0, cfg_rdata, ad;
  logic [15:0] io_addr = 16'h0;
  logic wide, done, ph, dreq, hit, en, sreq, msk, tc;
  logic [5:0] mode;
  int bad_count = 0, n_compared = 0, cycles = 0;

  distributed_dma_regs distributed_dma_regs_i (.CLK(clk), .RESET(rst), .CFG_WR(cfg_wr),
    .CFG_RD(cfg_rd), .CFG_ADDR(cfg_addr), .CFG_WDATA(cfg_wdata), .CFG_RDATA(cfg_rdata),
    .IO_WR(io_wr), .IO_RD(io_rd), .IO_ADDR(io_addr), .IO_WDATA(io_wdata),
    .IO_RDATA(io_rdata), .IO_HIT(hit), .CARD_DREQ(dreq), .XFER_WIDE(wide),
    .XFER_DONE(done), .ADDR_PHASE(ph), .AD_OUT(ad), .AD_OE(oe), .CONTROLLER_ENABLE(en),
    .SOFT_REQUEST(sreq), .MODE_BITS(mode), .CHANNEL_MASKED(msk), .TERMINAL_COUNT(tc));
  dma_master_model dma_master_model_i (.clk(clk), .ad(ad), .ad_oe(oe), .wide(wide),
    .done(done), .phase_req(ph), .dreq(dreq));

  always #4 clk = ~clk;

  // ==========================================================
  // helpers
  task automatic finish_test();
    if (bad_count == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // generous ceiling: the whole run is about 120 cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      bad_count++;
      finish_test();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic cfg(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(negedge clk);
    cfg_wr = w;
    cfg_rd = !w;
    cfg_addr = a;
    cfg_wdata = d;
    @(negedge clk);
    cfg_wr = 0;
    cfg_rd = 0;
  endtask

  task automatic io(input logic w, input logic [15:0] a, input logic [7:0] d);
    @(negedge clk);
    io_wr = w;
    io_rd = !w;
    io_addr = a;
    io_wdata = d;
    #1 h = hit;
    @(negedge clk);
    io_wr = 0;
    io_rd = 0;
  endtask

  function automatic logic [15:0] at(input logic [3:0] o);
    return {B[15:4], o};
  endfunction

  task automatic wr(input logic [3:0] o, input logic [7:0] d);
    io(1, at(o), d);
  endtask

  task automatic rd(input logic [3:0] o, input logic [7:0] exp);
    io(0, at(o), 8'h00);
    check(io_rdata, exp);
  endtask

  // ==========================================================
  // scenarios
  task automatic t_base();
    cfg(1, CFG_DMA_BASE_OFS, 32'h0000_0301);
    cfg(1, 8'h9C, 32'h0000_FFF0);
    cfg(0, CFG_DMA_BASE_OFS, 32'h0);
    check(cfg_rdata, 32'h0000_0300);
    cfg(0, 8'h9C, 32'h0);
    check(cfg_rdata, 32'h0);
    io(0, B + 16'h0010, 8'h00);
    check(h, 1'b0);
    io(0, at(4'hF), 8'h00);
    check(h, 1'b1);
  endtask

  task automatic t_regs();
    logic [3:0] rsv[6] = '{4'h3, 4'h6, 4'h7, 4'hA, 4'hC, 4'hE};
    wr(OFS_ADDR_LO, 8'h34);
    wr(OFS_ADDR_HI, 8'h12);
    wr(OFS_PAGE, 8'h57);
    foreach (rsv[i]) wr(rsv[i], 8'hFF);
    foreach (rsv[i]) rd(rsv[i], 8'h00);
    rd(OFS_ADDR_LO, 8'h34);
    rd(OFS_ADDR_HI, 8'h12);
    rd(OFS_PAGE, 8'h57);
    rd(OFS_MODE, 8'h00);
  endtask

  task automatic t_phase();
    dma_master_model_i.phase(1'b0);
    check(dma_master_model_i.got_ad, 32'h0057_1234);
    dma_master_model_i.phase(1'b1);
    check(dma_master_model_i.got_ad, 32'h0056_2468);
    check(dma_master_model_i.got_oe, 1'b1);
  endtask

  task automatic t_count();
    dma_master_model_i.request(1'b1);
    wr(OFS_COUNT_LO, 8'h03);
    wr(OFS_COUNT_HI, 8'h00);
    dma_master_model_i.xfer(1'b1);
    rd(OFS_COUNT_LO, 8'h01);
    dma_master_model_i.xfer(1'b0);
    rd(OFS_COUNT_LO, 8'h00);
    dma_master_model_i.xfer(1'b1);
    rd(OFS_COUNT_HI, 8'hFF);
    check(tc, 1'b1);
    rd(OFS_STAT_CMD, 8'hFF);
    rd(OFS_STAT_CMD, 8'hF0);
    rd(OFS_ADDR_LO, 8'h37);
  endtask

  task automatic t_ctrl();
    wr(OFS_REQUEST, 8'h01);
    wr(OFS_MODE, 8'hFC);
    wr(OFS_MULTI_MASK, 8'h00);
    check({sreq, mode, msk}, {1'b1, 6'h3F, 1'b0});
    rd(OFS_MULTI_MASK, 8'h00);
    wr(OFS_STAT_CMD, 8'h04);
    check(en, 1'b0);
    dma_master_model_i.phase(1'b0);
    check(dma_master_model_i.got_oe, 1'b0);
    dma_master_model_i.xfer(1'b0);
    rd(OFS_COUNT_LO, 8'hFE);
    wr(OFS_MASTER_CLR, 8'h00);
    check({en, sreq, msk}, 3'b101);
    check(mode, 6'h00);
    dma_master_model_i.request(1'b0);
    // two synchroniser stages before the status byte sees the drop
    @(negedge clk);
    rd(OFS_STAT_CMD, 8'h00);
  endtask

  // reset in mid-run must restore enable, mask and a silent window
  task automatic t_reset();
    wr(OFS_STAT_CMD, 8'h04);
    wr(OFS_MODE, 8'h0C);
    check(en, 1'b0);
    @(negedge clk);
    rst = 1'b1;
    repeat (3) @(negedge clk);
    rst = 1'b0;
    check({en, sreq, mode, msk, tc}, {1'b1, 1'b0, 6'h00, 1'b1, 1'b0});
    io(0, at(OFS_ADDR_LO), 8'h00);
    check(h, 1'b0);
    cfg(0, CFG_DMA_BASE_OFS, 32'h0);
    check(cfg_rdata, 32'h0);
  endtask

  initial begin
    repeat (12) @(negedge clk);
    rst = 0;
    check(en, 1'b1);
    t_base();
    t_regs();
    t_phase();
    t_count();
    t_ctrl();
    t_reset();
    finish_test();
  end
endmodule
